// ---- pkg/ddl_pkg.sv ----
package ddl_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int SETUP_NS = 40;
	localparam int STROBE_NS = 80;
	localparam int HOLD_NS = 40;
	localparam int LOAD_PULSE_NS = 80;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOAD_CYC =
		(LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 8;

	// ------------------------------------------------------------
	// Bus widths and fields
	// ------------------------------------------------------------
	localparam int CODE_W = 12;
	localparam int BYTE_W = 8;
	localparam int NIB_W = 4;
	localparam int LOW_MSB = 7;
	localparam int HIGH_MSB = 11;
	localparam int HIGH_LSB = 8;
	localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;

	// Portion index: {channel b, high nibble}
	localparam logic [1:0] PORT_A_LOW = 2'h0;
	localparam logic [1:0] PORT_B_LOW = 2'h2;
	localparam logic [2:0] PORT_NONE = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_STROBE = 3'b010,
		ST_HOLD = 3'b011,
		ST_LOAD = 3'b100
	} ddl_state_t;

endpackage

// ---- rtl/ddl_step_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module ddl_step_timer
#(
	parameter int WIDTH = 8
)
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Control
	input wire logic load_i,
	input wire logic [WIDTH-1:0] value_i,
	// Status
	output logic expired_o
);

	logic [WIDTH-1:0] count;

	assign expired_o = (count == '0);

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			count <= '0;
		else if (load_i)
			count <= value_i;
		else if (!expired_o)
			count <= count - 1'b1;
	end

endmodule
`default_nettype wire

// ---- rtl/ddl_host.sv ----
// Summary of operation
// - Host sends right-justified data; high nibble on lowest four lines.
// - Portions may be written in any order; host writes low then high.
// - Host keeps load strobe apart from select-and-write cycles.
// - In gain use the host refuses code zero for an enabled channel.
`timescale 1ns/10ps
`default_nettype none
module ddl_host
	import ddl_pkg::*;
#(
	parameter int SETUP_CYCLES = ddl_pkg::SETUP_CYC,
	parameter int STROBE_CYCLES = ddl_pkg::STROBE_CYC,
	parameter int HOLD_CYCLES = ddl_pkg::HOLD_CYC,
	parameter int LOAD_CYCLES = ddl_pkg::LOAD_CYC
)
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// User command
	input wire logic req_i,
	input wire logic chan_a_en_i,
	input wire logic chan_b_en_i,
	input wire logic [ddl_pkg::CODE_W-1:0] code_a_i,
	input wire logic [ddl_pkg::CODE_W-1:0] code_b_i,
	input wire logic update_i,
	input wire logic gain_mode_i,
	// User status
	output logic busy_o,
	output logic done_o,
	output logic refused_o,
	// Parallel-port device pins
	output logic [ddl_pkg::CODE_W-1:0] par_data_o,
	output logic select_chan_a_n_o,
	output logic select_chan_b_n_o,
	output logic par_write_n_o,
	// Byte-port device pins
	output logic [ddl_pkg::BYTE_W-1:0] byte_data_o,
	output logic byte_cs_n_o,
	output logic byte_write_n_o,
	output logic addr_high_bit_o,
	output logic addr_low_bit_o,
	output logic load_dac_strobe_n_o
);

	import ddl_pkg::*;

	ddl_state_t state;
	ddl_state_t next_state;
	logic [1:0] step;
	logic [1:0] next_step;
	logic [CODE_W-1:0] code_a;
	logic [CODE_W-1:0] code_b;
	logic en_a;
	logic en_b;
	logic do_update;
	logic timer_load;
	logic [TIMER_W-1:0] timer_value;
	logic expired;

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	wire idle = (state == ST_IDLE);
	wire zero_a = chan_a_en_i && (code_a_i == CODE_ZERO);
	wire zero_b = chan_b_en_i && (code_b_i == CODE_ZERO);
	wire bad_cmd = gain_mode_i && (zero_a || zero_b);
	wire accept = idle && req_i && !bad_cmd;
	wire next_en_a = accept ? chan_a_en_i : en_a;
	wire next_en_b = accept ? chan_b_en_i : en_b;
	wire next_upd = accept ? update_i : do_update;
	wire [CODE_W-1:0] next_code_a = accept ? code_a_i : code_a;
	wire [CODE_W-1:0] next_code_b = accept ? code_b_i : code_b;

	// First enabled portion at or after a start index
	function automatic logic [2:0] find_port(input logic [2:0] from,
		input logic ea, input logic eb);
		logic [2:0] res;
		res = PORT_NONE;
		for (int k = 3; k >= 0; k--)
		begin
			if (k >= from && ((k >= 2) ? eb : ea))
				res = 3'(k);
		end
		return res;
	endfunction

	wire [2:0] first_port = find_port(3'h0, next_en_a, next_en_b);
	wire [2:0] later_port = find_port(3'({1'b0, step}) + 3'h1, en_a, en_b);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_step = step;
		timer_load = 1'b0;
		timer_value = '0;
		case (state)
			ST_IDLE:
			begin
				if (accept && !first_port[2])
				begin
					next_state = ST_SETUP;
					next_step = first_port[1:0];
				end
				else if (accept && next_upd)
					next_state = ST_LOAD;
			end
			ST_SETUP:
				if (expired)
					next_state = ST_STROBE;
			ST_STROBE:
				if (expired)
					next_state = ST_HOLD;
			ST_HOLD:
			begin
				if (expired && !later_port[2])
				begin
					next_state = ST_SETUP;
					next_step = later_port[1:0];
				end
				else if (expired)
					next_state = do_update ? ST_LOAD : ST_IDLE;
			end
			ST_LOAD:
				if (expired)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
		if (next_state != state || next_step != step)
		begin
			timer_load = 1'b1;
			case (next_state)
				ST_SETUP: timer_value = TIMER_W'(SETUP_CYCLES - 1);
				ST_STROBE: timer_value = TIMER_W'(STROBE_CYCLES - 1);
				ST_HOLD: timer_value = TIMER_W'(HOLD_CYCLES - 1);
				ST_LOAD: timer_value = TIMER_W'(LOAD_CYCLES - 1);
				default: timer_value = '0;
			endcase
		end
	end

	ddl_step_timer #(.WIDTH(TIMER_W)) u_timer (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.load_i(timer_load),
		.value_i(timer_value),
		.expired_o(expired)
	);

	// ------------------------------------------------------------
	// Pin values for the coming cycle
	// ------------------------------------------------------------
	wire cycle_on = (next_state == ST_SETUP) || (next_state == ST_STROBE) ||
		(next_state == ST_HOLD);
	wire strobe_on = (next_state == ST_STROBE);
	wire [CODE_W-1:0] sel_code = next_step[1] ? next_code_b : next_code_a;
	wire [BYTE_W-1:0] low_part = sel_code[LOW_MSB:0];
	wire [BYTE_W-1:0] high_part =
		{{(BYTE_W-NIB_W){1'b0}}, sel_code[HIGH_MSB:HIGH_LSB]};
	wire [BYTE_W-1:0] next_byte = next_step[0] ? high_part : low_part;
	wire par_a = cycle_on && (next_step == PORT_A_LOW);
	wire par_b = cycle_on && (next_step == PORT_B_LOW);
	wire finish = (state == ST_HOLD || state == ST_LOAD) && expired &&
		next_state == ST_IDLE;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state <= ST_IDLE;
			step <= 2'h0;
			code_a <= CODE_ZERO;
			code_b <= CODE_ZERO;
			en_a <= 1'b0;
			en_b <= 1'b0;
			do_update <= 1'b0;
		end
		else
		begin
			state <= next_state;
			step <= next_step;
			code_a <= next_code_a;
			code_b <= next_code_b;
			en_a <= next_en_a;
			en_b <= next_en_b;
			do_update <= next_upd;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			refused_o <= 1'b0;
			par_data_o <= CODE_ZERO;
			select_chan_a_n_o <= 1'b1;
			select_chan_b_n_o <= 1'b1;
			par_write_n_o <= 1'b1;
			byte_data_o <= '0;
			byte_cs_n_o <= 1'b1;
			byte_write_n_o <= 1'b1;
			addr_high_bit_o <= 1'b0;
			addr_low_bit_o <= 1'b0;
			load_dac_strobe_n_o <= 1'b1;
		end
		else
		begin
			busy_o <= (next_state != ST_IDLE);
			done_o <= finish;
			refused_o <= idle && req_i && bad_cmd;
			par_data_o <= sel_code;
			select_chan_a_n_o <= !par_a;
			select_chan_b_n_o <= !par_b;
			par_write_n_o <= !(strobe_on && (par_a || par_b));
			byte_data_o <= next_byte;
			byte_cs_n_o <= !cycle_on;
			byte_write_n_o <= !strobe_on;
			addr_high_bit_o <= next_step[1];
			addr_low_bit_o <= next_step[0];
			load_dac_strobe_n_o <= !(next_state == ST_LOAD);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_load_apart_write: assert property (
		@(posedge clock_i) disable iff (rst_i)
		!load_dac_strobe_n_o |-> byte_cs_n_o && byte_write_n_o &&
			par_write_n_o)
		else $error("load strobe overlaps a write cycle");

	chk_nibble_right_just: assert property (
		@(posedge clock_i) disable iff (rst_i)
		!byte_cs_n_o && addr_low_bit_o |-> byte_data_o[LOW_MSB:NIB_W] == '0)
		else $error("high nibble not right-justified");

	chk_gain_zero_refused: assert property (
		@(posedge clock_i) disable iff (rst_i)
		idle && req_i && gain_mode_i && (zero_a || zero_b)
			|=> refused_o && !busy_o)
		else $error("zero code accepted in gain mode");

	chk_write_data_stable: assert property (
		@(posedge clock_i) disable iff (rst_i)
		$rose(byte_write_n_o) |-> !byte_cs_n_o &&
			$stable(byte_data_o) && $stable(addr_low_bit_o) &&
			$stable(addr_high_bit_o))
		else $error("write edge without stable address and data");

	chk_load_pulse_len: assert property (
		@(posedge clock_i) disable iff (rst_i)
		$fell(load_dac_strobe_n_o) |-> !load_dac_strobe_n_o [*1] ##1
			(LOAD_CYCLES > 1 ? !load_dac_strobe_n_o : 1'b1))
		else $error("load strobe pulse too short");

endmodule
`default_nettype wire

// ---- verif/ddl_dev_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module ddl_dev_model
	import ddl_pkg::*;
(
	// Parallel port
	input wire logic [ddl_pkg::CODE_W-1:0] par_data_i,
	input wire logic select_chan_a_n_i,
	input wire logic select_chan_b_n_i,
	input wire logic par_write_n_i,
	// Byte port
	input wire logic [ddl_pkg::BYTE_W-1:0] byte_data_i,
	input wire logic byte_cs_n_i,
	input wire logic byte_write_n_i,
	input wire logic addr_high_bit_i,
	input wire logic addr_low_bit_i,
	input wire logic load_dac_strobe_n_i,
	// Latch contents
	output logic [ddl_pkg::CODE_W-1:0] par_a_o,
	output logic [ddl_pkg::CODE_W-1:0] par_b_o,
	output logic [ddl_pkg::CODE_W-1:0] dac_a_o,
	output logic [ddl_pkg::CODE_W-1:0] dac_b_o
);
	// No initial values: latches start unknown
	logic [ddl_pkg::CODE_W-1:0] in_a;
	logic [ddl_pkg::CODE_W-1:0] in_b;
	wire logic open_w = !byte_cs_n_i && !byte_write_n_i;

	always @(posedge par_write_n_i)
	begin
		if (!select_chan_a_n_i)
			par_a_o <= par_data_i;
		if (!select_chan_b_n_i)
			par_b_o <= par_data_i;
	end

	always_latch
	begin
		if (open_w)
			case ({addr_high_bit_i, addr_low_bit_i})
				2'h0: in_a[7:0] = byte_data_i;
				2'h1: in_a[11:8] = byte_data_i[3:0];
				2'h2: in_b[7:0] = byte_data_i;
				default: in_b[11:8] = byte_data_i[3:0];
			endcase
	end

	// Outputs follow only the DAC latches; codes kept as raw binary
	always_latch
	begin
		if (!load_dac_strobe_n_i)
		begin
			dac_a_o = in_a;
			dac_b_o = in_b;
		end
	end
endmodule
`default_nettype wire

// ---- verif/dual_dac_latch_interface_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module dual_dac_latch_interface_tb;
	import ddl_pkg::*;
	typedef struct packed
	{
		logic ea;
		logic eb;
		logic [11:0] ca;
		logic [11:0] cb;
		logic up;
		logic [11:0] pa;
		logic [11:0] pb;
		logic [11:0] da;
		logic [11:0] db;
	} ddl_row_t;
	// Inputs, then expected parallel and DAC latches
	ddl_row_t rows [6] = '{
		'{1'h1,1'h1,12'hABC,12'h5A3,1'h1,12'hABC,12'h5A3,12'hABC,12'h5A3},
		'{1'h1,1'h0,12'h123,12'h000,1'h0,12'h123,12'h5A3,12'hABC,12'h5A3},
		'{1'h0,1'h0,12'h000,12'h000,1'h1,12'h123,12'h5A3,12'h123,12'h5A3},
		'{1'h0,1'h1,12'h000,12'h800,1'h1,12'h123,12'h800,12'h123,12'h800},
		'{1'h1,1'h1,12'hFFF,12'h001,1'h1,12'hFFF,12'h001,12'hFFF,12'h001},
		'{1'h1,1'h1,12'h000,12'hFFF,1'h1,12'h000,12'hFFF,12'h000,12'hFFF}
	};
	logic clock_i, rst_i, req, ea, eb, upd, gm, got_done, got_ref;
	logic [11:0] ca, cb, pd, pa, pb, da, db;
	logic [7:0] bd;
	logic busy, done, refused, sa_n, sb_n, pw_n, cs_n, bw_n, ah, al, ld_n;
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;

	ddl_host i_ddl_host (.clock_i(clock_i), .rst_i(rst_i), .req_i(req),
		.chan_a_en_i(ea), .chan_b_en_i(eb), .code_a_i(ca), .code_b_i(cb),
		.update_i(upd), .gain_mode_i(gm), .busy_o(busy), .done_o(done),
		.refused_o(refused), .par_data_o(pd), .select_chan_a_n_o(sa_n),
		.select_chan_b_n_o(sb_n), .par_write_n_o(pw_n), .byte_data_o(bd),
		.byte_cs_n_o(cs_n), .byte_write_n_o(bw_n), .addr_high_bit_o(ah),
		.addr_low_bit_o(al), .load_dac_strobe_n_o(ld_n));

	ddl_dev_model i_ddl_dev_model (.par_data_i(pd), .select_chan_a_n_i(sa_n),
		.select_chan_b_n_i(sb_n), .par_write_n_i(pw_n), .byte_data_i(bd),
		.byte_cs_n_i(cs_n), .byte_write_n_i(bw_n), .addr_high_bit_i(ah),
		.addr_low_bit_i(al), .load_dac_strobe_n_i(ld_n), .par_a_o(pa),
		.par_b_o(pb), .dac_a_o(da), .dac_b_o(db));

	always #20 clock_i = ~clock_i;

	task automatic wrap_up;
		$display("Compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One command; host never overlaps load with a write
	task automatic run(input logic a, input logic b, input logic [11:0] x,
		input logic [11:0] y, input logic u, input logic g);
		int k;
		@(negedge clock_i);
		ea = a;
		eb = b;
		ca = x;
		cb = y;
		upd = u;
		gm = g;
		req = 1'h1;
		got_done = 1'h0;
		got_ref = 1'h0;
		for (k = 0; k < 60 && !got_done && !got_ref; k++)
		begin
			@(negedge clock_i);
			req = 1'h0;
			got_done = done === 1'h1;
			got_ref = refused === 1'h1;
		end
	endtask

	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			wrap_up();
		end
	end

	initial
	begin
		{clock_i, rst_i, req, ea, eb, upd, gm} = 7'h20;
		ca = 12'h000;
		cb = 12'h000;
		repeat (6) @(posedge clock_i);
		@(negedge clock_i);
		check({6'h0, sa_n, sb_n, pw_n, cs_n, bw_n, ld_n}, 12'h03F);
		check({9'h0, busy, done, refused}, 12'h000);
		rst_i = 1'h0;
		foreach (rows[i])
		begin
			run(rows[i].ea, rows[i].eb, rows[i].ca, rows[i].cb, rows[i].up,
				1'h0);
			check({11'h0, got_done}, 12'h001);
			check(pa, rows[i].pa);
			check(pb, rows[i].pb);
			check(da, rows[i].da);
			check(db, rows[i].db);
		end
		run(1'h1, 1'h1, 12'h000, 12'hABC, 1'h1, 1'h1);
		check({11'h0, got_ref}, 12'h001);
		check(pb, 12'hFFF);
		check(db, 12'hFFF);
		run(1'h1, 1'h0, 12'h001, 12'h000, 1'h1, 1'h1);
		check(da, 12'h001);
		run(1'h0, 1'h0, 12'h000, 12'h000, 1'h0, 1'h0);
		check({10'h0, got_done, got_ref}, 12'h000);
		check(da, 12'h001);
		// Reset in mid-command, then a clean command
		@(negedge clock_i);
		ea = 1'h1;
		eb = 1'h0;
		ca = 12'h5A5;
		upd = 1'h1;
		gm = 1'h0;
		req = 1'h1;
		@(negedge clock_i);
		req = 1'h0;
		check({10'h0, busy, cs_n}, 12'h002);
		rst_i = 1'h1;
		@(negedge clock_i);
		check({6'h0, sa_n, sb_n, pw_n, cs_n, bw_n, ld_n}, 12'h03F);
		check({9'h0, busy, done, refused}, 12'h000);
		check(da, 12'h001);
		rst_i = 1'h0;
		run(1'h1, 1'h0, 12'h5A5, 12'h000, 1'h1, 1'h0);
		check({11'h0, got_done}, 12'h001);
		check(pa, 12'h5A5);
		check(da, 12'h5A5);
		wrap_up();
	end
endmodule
`default_nettype wire
